// ===== src/rct_pkg.sv
// package: constants and carrier types for the reload/capture timer pair
package rct_pkg;
	localparam int          RCT_WIDTH       = 16;
	localparam int          RCT_INSTANCES   = 2;
	localparam int          RCT_TIMER_DIV   = 12;   // pclk periods per timer tick
	localparam int          RCT_DIV_W       = 4;
	localparam logic [15:0] RCT_ALL_ONES    = 16'hFFFF;
	localparam logic [15:0] RCT_ZERO        = 16'h0000;
	localparam logic [15:0] RCT_COUNT_RST   = 16'h0000;
	localparam logic [15:0] RCT_RELOAD_RST  = 16'h0000;
	localparam logic [1:0]  RCT_SYNC_RST    = 2'h0;

	// per-instance configuration bits
	typedef struct packed {
		logic        run;          // counting enabled
		logic        capture_mode; // 1: capture, 0: auto-reload
		logic        counter_fn;   // 1: count pin falling edges, 0: pclk/12
		logic        updown_en;    // direction follows trigger pin level
		logic        trig_en;      // trigger pin edge reloads/captures
		logic        trig_rising;  // 1: rising edge, 0: falling edge
	} rct_cfg_t;

	// per-instance observed state
	typedef struct packed {
		logic [15:0] timer_count_value;
		logic [15:0] reload_capture_value;
		logic        irq;          // one-cycle event pulse
		logic        flag;         // sticky event flag
	} rct_stat_t;
endpackage : rct_pkg

// ===== src/rct_edge_sync.sv
// module: pin synchroniser with level output and edge strobes
`timescale 1ns/100ps
module rct_edge_sync (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	// pin
	input  wire logic i_pin,
	// sampled results
	output logic      o_level,
	output logic      o_fall,
	output logic      o_rise
);
	import rct_pkg::*;

	logic [1:0] sync_r;
	logic       prev_r;
	logic [2:0] fill_r; // marks when prev_r holds a real pin sample
	logic       primed;

	// two-stage sync, then one more stage for edge compare
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync_r <= RCT_SYNC_RST;
			prev_r <= 1'b0;
			fill_r <= 3'h0;
		end else begin
			sync_r <= {sync_r[0], i_pin};
			prev_r <= sync_r[1];
			fill_r <= {fill_r[1:0], 1'b1};
		end
	end

	// no strobes until the pipeline is filled, so an idle-high pin gives no edge after reset
	assign primed  = fill_r[2];
	assign o_level = sync_r[1];
	assign o_fall  = primed & prev_r & ~sync_r[1];
	assign o_rise  = primed & ~prev_r & sync_r[1];
endmodule : rct_edge_sync

// ===== src/rct_tick_div.sv
// module: divider making the one-cycle timer tick enable
`timescale 1ns/100ps
module rct_tick_div #(
	parameter int DIV = rct_pkg::RCT_TIMER_DIV
) (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	// tick enable
	output logic      o_tick
);
	import rct_pkg::*;

	initial begin
		if (DIV < 2 || DIV > 15) $error("rct_tick_div: DIV out of range");
	end

	logic [RCT_DIV_W-1:0] cnt_r;
	logic [RCT_DIV_W-1:0] cnt_nxt;
	logic                 wrap;

	// wrap after DIV cycles
	assign wrap    = (cnt_r == RCT_DIV_W'(DIV - 1));
	assign cnt_nxt = wrap ? '0 : cnt_r + 1'b1;

	// counter and registered tick, one pulse per DIV clocks
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r  <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			o_tick <= wrap;
		end
	end
endmodule : rct_tick_div

// ===== src/rct_timer.sv
// module: pair of 16-bit auto-reload / capture timer counters
// Overview of operation
// - Two identical 16-bit timers, each in auto-reload or capture mode.
// - Timer function advances once per twelve clock periods.
// - Counter function advances on each falling edge of the count pin.
// - Auto-reload, no up/down: counts up from reload value, overflows past all-ones.
// - Without up/down, reload on overflow only or also on chosen trigger edge.
// - Without up/down, reload copies reload value and raises interrupt.
// - Up/down enabled: trigger pin level sets direction, no interrupt.
// - Up/down counting up: overflow past all-ones reloads reload value.
// - Up/down counting down: at reload value, reload with all-ones.
// - Capture mode counts up from zero and wraps to zero.
// - Capture mode: chosen trigger edge stores count into reload/capture value.
// - Capture mode: interrupt on every overflow and every capture.
`timescale 1ns/100ps
module rct_timer #(
	parameter int N_TIMERS = rct_pkg::RCT_INSTANCES,
	parameter int WIDTH    = rct_pkg::RCT_WIDTH,
	parameter int DIV      = rct_pkg::RCT_TIMER_DIV
) (
	// clock and reset
	input  wire logic                i_clock,
	input  wire logic                i_sys_rst,
	// configuration, one entry per timer
	input  wire rct_pkg::rct_cfg_t   i_cfg [N_TIMERS],
	// software writes
	input  wire logic [N_TIMERS-1:0] i_reload_wr,
	input  wire logic [15:0]         i_reload_wdata [N_TIMERS],
	input  wire logic [N_TIMERS-1:0] i_count_wr,
	input  wire logic [15:0]         i_count_wdata [N_TIMERS],
	input  wire logic [N_TIMERS-1:0] i_flag_clr,
	// pins
	input  wire logic [N_TIMERS-1:0] i_count_input_pin,
	input  wire logic [N_TIMERS-1:0] i_trigger_direction_pin,
	// status
	output rct_pkg::rct_stat_t       o_stat [N_TIMERS]
);
	import rct_pkg::*;

	initial begin
		if (WIDTH != RCT_WIDTH) $error("rct_timer: only 16-bit counters supported");
		if (N_TIMERS < 1) $error("rct_timer: need at least one timer");
	end

	logic tick;

	// shared timer-function tick, pclk/12
	rct_tick_div #(
		.DIV    (DIV)
	) u_div (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.o_tick    (tick)
	);

	// one timer slice per instance
	for (genvar g = 0; g < N_TIMERS; g++) begin : g_tmr
		logic        cnt_lvl;
		logic        cnt_fall;
		logic        cnt_rise;
		logic        trg_lvl;
		logic        trg_fall;
		logic        trg_rise;
		logic [15:0] count_r;
		logic [15:0] count_nxt;
		logic [15:0] rc_r;
		logic [15:0] rc_nxt;
		logic        irq_r;
		logic        flag_r;
		logic        step;
		logic        trg_edge;
		logic        down;
		logic        at_top;
		logic        at_floor;
		logic        ovf;
		logic        unf;
		logic        trg_reload;
		logic        capture;
		logic        event_irq;
		rct_cfg_t    cfg;

		rct_edge_sync u_cnt_sync (
			.i_clock   (i_clock),
			.i_sys_rst (i_sys_rst),
			.i_pin     (i_count_input_pin[g]),
			.o_level   (cnt_lvl),
			.o_fall    (cnt_fall),
			.o_rise    (cnt_rise)
		);

		rct_edge_sync u_trg_sync (
			.i_clock   (i_clock),
			.i_sys_rst (i_sys_rst),
			.i_pin     (i_trigger_direction_pin[g]),
			.o_level   (trg_lvl),
			.o_fall    (trg_fall),
			.o_rise    (trg_rise)
		);

		assign cfg = i_cfg[g];

		// count step source: divided clock or falling pin edge
		assign step     = cfg.run & (cfg.counter_fn ? cnt_fall : tick);
		assign trg_edge = cfg.trig_rising ? trg_rise : trg_fall;
		assign down     = ~cfg.capture_mode & cfg.updown_en & ~trg_lvl;

		// boundary decode
		assign at_top   = (count_r == RCT_ALL_ONES);
		assign at_floor = (count_r == rc_r);
		assign ovf      = step & ~down & at_top;
		assign unf      = step & down & at_floor;
		assign trg_reload = cfg.run & ~cfg.capture_mode & ~cfg.updown_en
		                    & cfg.trig_en & trg_edge;
		assign capture  = cfg.run & cfg.capture_mode & cfg.trig_en & trg_edge;

		// interrupt events: none with up/down enabled in auto-reload mode
		assign event_irq = cfg.capture_mode ? (ovf | capture)
		                 : (~cfg.updown_en & (ovf | trg_reload));

		// next count value, reload takes priority over stepping
		assign count_nxt = i_count_wr[g] ? i_count_wdata[g]
		                 : (cfg.capture_mode & ovf) ? RCT_ZERO
		                 : (trg_reload | ovf) ? rc_r
		                 : unf ? RCT_ALL_ONES
		                 : (step & down) ? count_r - 16'h0001
		                 : step ? count_r + 16'h0001
		                 : count_r;

		// capture beats a software write in the same cycle
		assign rc_nxt = capture ? count_r
		              : i_reload_wr[g] ? i_reload_wdata[g]
		              : rc_r;

		// state registers
		always_ff @(posedge i_clock or posedge i_sys_rst) begin
			if (i_sys_rst) begin
				count_r <= RCT_COUNT_RST;
				rc_r    <= RCT_RELOAD_RST;
				irq_r   <= 1'b0;
				flag_r  <= 1'b0;
			end else begin
				count_r <= count_nxt;
				rc_r    <= rc_nxt;
				irq_r   <= event_irq;
				flag_r  <= event_irq | (flag_r & ~i_flag_clr[g]);
			end
		end

		// status outputs straight from flops
		assign o_stat[g] = '{timer_count_value:    count_r,
		                     reload_capture_value: rc_r,
		                     irq:                  irq_r,
		                     flag:                 flag_r};
	end
endmodule : rct_timer

// ===== bench/rct_timer_assertions.sv
// checker: timing relations of timer 0 status outputs
`timescale 1ns/100ps
module rct_timer_chk #(parameter int N_TIMERS = 2, WIDTH = 16, DIV = 12) (
	// watched ports
	input wire logic                i_clock,
	input wire logic                i_sys_rst,
	input wire rct_pkg::rct_cfg_t   i_cfg [N_TIMERS],
	input wire logic [N_TIMERS-1:0] i_reload_wr,
	input wire logic [15:0]         i_reload_wdata [N_TIMERS],
	input wire logic [N_TIMERS-1:0] i_count_wr,
	input wire logic [15:0]         i_count_wdata [N_TIMERS],
	input wire logic [N_TIMERS-1:0] i_flag_clr,
	input wire logic [N_TIMERS-1:0] i_count_input_pin,
	input wire logic [N_TIMERS-1:0] i_trigger_direction_pin,
	input wire rct_pkg::rct_stat_t  o_stat [N_TIMERS]
);
	import rct_pkg::*;
	rct_cfg_t  c;
	rct_stat_t s;
	// timer 0 views
	assign c = i_cfg[0];
	assign s = o_stat[0];
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	a_irq_one_cycle: assert property (s.irq |=> !s.irq) else $error("irq too wide");
	a_flag_on_irq: assert property (s.irq |-> s.flag) else $error("flag missed");
	a_flag_sticky: assert property (s.flag && !i_flag_clr[0] |=> s.flag)
		else $error("flag dropped");
	a_updown_quiet: assert property (c.updown_en && !c.capture_mode && $past(c.updown_en)
		|-> !s.irq) else $error("irq in up/down");
	a_stop_holds: assert property (!c.run && !i_count_wr[0]
		|=> $stable(s.timer_count_value)) else $error("count moved while stopped");
	a_reload_write: assert property (i_reload_wr[0] && !c.capture_mode
		|=> s.reload_capture_value == $past(i_reload_wdata[0])) else $error("reload write");
	a_count_write: assert property (i_count_wr[0]
		|=> s.timer_count_value == $past(i_count_wdata[0])) else $error("count write");
	a_tick_spacing: assert property ($changed(s.timer_count_value) && c.run && !c.counter_fn
		&& !c.trig_en && !i_count_wr[0] && !$past(i_count_wr[0])
		|=> $stable(s.timer_count_value)) else $error("ticks too close");
	a_capture_irq: assert property (c.capture_mode && $changed(s.reload_capture_value)
		&& !$past(i_reload_wr[0]) |-> ##[0:1] s.irq) else $error("capture without irq");
	c_capture: cover property (c.capture_mode && s.irq);
	c_reload: cover property (!c.capture_mode && s.irq);
	c_down: cover property (c.updown_en && s.timer_count_value == 16'hFFFF);
endmodule // rct_timer_chk

bind rct_timer rct_timer_chk #(.N_TIMERS(N_TIMERS), .WIDTH(WIDTH), .DIV(DIV)) u_chk (
	.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cfg(i_cfg), .i_reload_wr(i_reload_wr),
	.i_reload_wdata(i_reload_wdata), .i_count_wr(i_count_wr), .i_count_wdata(i_count_wdata),
	.i_flag_clr(i_flag_clr), .i_count_input_pin(i_count_input_pin),
	.i_trigger_direction_pin(i_trigger_direction_pin), .o_stat(o_stat));

// ===== bench/rct_pin_model.sv
// model: external drivers of the count and trigger/direction pins
`timescale 1ns/100ps
module rct_pin_model (
	// clock
	input  wire logic  i_clock,
	// pins, both timers driven alike
	output logic [1:0] o_count_pin,
	output logic [1:0] o_trig_pin
);
	// pins idle high
	initial begin
		o_count_pin = 2'h3;
		o_trig_pin  = 2'h3;
	end
	// one falling edge, each level held 12 clocks so edges stay 24 apart
	task automatic count_pulse();
		repeat (12) @(negedge i_clock);
		o_count_pin = 2'h0;
		repeat (12) @(negedge i_clock);
		o_count_pin = 2'h3;
	endtask
	// new trigger/direction level, then time for the synchroniser
	task automatic trig_level(input logic v);
		@(negedge i_clock);
		o_trig_pin = {v, v};
		repeat (6) @(negedge i_clock);
	endtask
endmodule // rct_pin_model

// ===== bench/tb_rct_timer.sv
// testbench: scenarios for the reload/capture timer pair
`timescale 1ns/100ps
module tb_rct_timer;
	import rct_pkg::*;
	logic        clk, rst;
	rct_cfg_t    cfg [2];
	logic [1:0]  rwr, cwr, fclr, cpin, tpin;
	logic [15:0] rdat [2], cdat [2];
	rct_stat_t   st [2];
	int          n_mismatch = 0, n_compared = 0;
	rct_timer #(.DIV(2)) dut (.i_clock(clk), .i_sys_rst(rst), .i_cfg(cfg), .i_reload_wr(rwr),
		.i_reload_wdata(rdat), .i_count_wr(cwr), .i_count_wdata(cdat), .i_flag_clr(fclr),
		.i_count_input_pin(cpin), .i_trigger_direction_pin(tpin), .o_stat(st));
	rct_pin_model pm (.i_clock(clk), .o_count_pin(cpin), .o_trig_pin(tpin));
	// compare one value
	task automatic cmp16(input string what, input logic [15:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// check both timers
	task automatic chk(input logic [15:0] ec, er, input logic ef);
		for (int g = 0; g < 2; g++) begin
			cmp16("count", ec, st[g].timer_count_value);
			cmp16("reload", er, st[g].reload_capture_value);
			cmp16("flag", {15'h0, ef}, {15'h0, st[g].flag});
		end
	endtask
	// program config, count and reload value, clear the flag
	task automatic setup(input rct_cfg_t c, input logic [15:0] cv, rv);
		@(negedge clk);
		cfg = '{c, c};
		cdat = '{cv, cv};
		rdat = '{rv, rv};
		{rwr, cwr, fclr} = 6'h3F;
		@(negedge clk);
		{rwr, cwr, fclr} = 6'h00;
	endtask
	// bounded wait for the sticky flag
	task automatic wait_flag();
		for (int i = 0; i < 60 && st[0].flag !== 1'b1; i++) @(negedge clk);
	endtask
	// verdict
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end
	initial begin
		rst = 1'b1;
		cfg = '{default: '0};
		rdat = '{default: '0};
		cdat = '{default: '0};
		{rwr, cwr, fclr} = 6'h00;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		chk(16'h0000, 16'h0000, 1'b0);
		setup(6'h20, 16'hFFFE, 16'hFFFE);
		wait_flag();
		chk(16'hFFFE, 16'hFFFE, 1'b1);
		setup(6'h00, 16'h0123, 16'hFFFE);
		repeat (10) @(negedge clk);
		chk(16'h0123, 16'hFFFE, 1'b0);
		setup(6'h2B, 16'h0005, 16'h00AB);
		pm.trig_level(1'b0);
		chk(16'h0005, 16'h00AB, 1'b0);
		pm.trig_level(1'b1);
		chk(16'h00AB, 16'h00AB, 1'b1);
		setup(6'h3A, 16'h1234, 16'h0000);
		pm.trig_level(1'b0);
		chk(16'h1234, 16'h1234, 1'b1);
		setup(6'h3A, 16'hFFFF, 16'h1234);
		pm.count_pulse();
		chk(16'h0000, 16'h1234, 1'b1);
		setup(6'h2C, 16'h0011, 16'h0010);
		pm.count_pulse();
		chk(16'h0010, 16'h0010, 1'b0);
		pm.count_pulse();
		chk(16'hFFFF, 16'h0010, 1'b0);
		pm.trig_level(1'b1);
		pm.count_pulse();
		chk(16'h0010, 16'h0010, 1'b0);
		end_of_test();
	end
endmodule // tb_rct_timer
